//--- design/tce_errq.sv
// Error queue held in flip-flops, read one entry at a time
`timescale 1ns/1ns
module tce_errq (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // Link to command logic
  tce_link_if.queue lk
);

  typedef struct packed {
    logic [tce_pkg::ERRQ_DEPTH-1:0][15:0] num;
    logic [tce_pkg::ERRQ_DEPTH-1:0][7:0] msg;
    logic [tce_pkg::ERRQ_AW-1:0] rd;
    logic [tce_pkg::ERRQ_AW-1:0] wr;
    logic [tce_pkg::ERRQ_AW:0] cnt;
  } tce_errq_st_t;

  tce_errq_st_t st_reg;
  tce_errq_st_t st_next;

  // ****************************************************************
  // Queue update
  // ****************************************************************
  // Clear beats a same-cycle push: a reset command must leave it empty
  always_comb begin
    st_next = st_reg;
    if (lk.clear) begin
      st_next.rd = '0;
      st_next.wr = '0;
      st_next.cnt = '0;
    end else begin
      if (lk.pop && st_reg.cnt != '0) begin
        st_next.rd = st_reg.rd + 1'b1;
        st_next.cnt = st_next.cnt - 1'b1;
      end
      if (lk.push) begin
        if (st_next.cnt == (tce_pkg::ERRQ_AW+1)'(tce_pkg::ERRQ_DEPTH)) begin
          // Full: newest slot now says entries were lost
          st_next.num[st_reg.wr - 1'b1] = tce_pkg::ERR_QUEUE_OVERFLOW;
          st_next.msg[st_reg.wr - 1'b1] = tce_pkg::TXT_QUEUE_OVERFLOW;
        end else begin
          st_next.num[st_reg.wr] = lk.push_num;
          st_next.msg[st_reg.wr] = lk.push_msg;
          st_next.wr = st_reg.wr + 1'b1;
          st_next.cnt = st_next.cnt + 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Head of queue seen by the command logic
  assign lk.head_num = st_reg.num[st_reg.rd];
  assign lk.head_msg = st_reg.msg[st_reg.rd];
  assign lk.empty = (st_reg.cnt == '0);

  a_clear_empties: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    lk.clear |=> lk.empty
  ) else $error("queue not empty after clear");

  a_pop_removes_one: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (lk.pop && !lk.push && !lk.clear && !lk.empty)
      |=> st_reg.cnt == $past(st_reg.cnt) - 1'b1
  ) else $error("read did not remove exactly one entry");

endmodule

//--- design/tce_filt.sv
// Rising-edge transition filter with sticky event bits
`timescale 1ns/1ns
module tce_filt (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // Link to command logic
  tce_link_if.filt lk
);

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] cond_prev;
    logic [15:0] event_bits;
  } tce_filt_st_t;

  tce_filt_st_t st_reg;
  tce_filt_st_t st_next;
  logic [15:0] rise;

  // ****************************************************************
  // Filter and event latch
  // ****************************************************************
  // A rise in the read cycle still lands: set wins over clear
  always_comb begin
    st_next = st_reg;
    rise = st_reg.mask & lk.cond & ~st_reg.cond_prev;
    st_next.cond_prev = lk.cond;
    st_next.event_bits = (lk.ev_rd ? 16'h0000 : st_reg.event_bits) | rise;
    if (lk.mask_wr) begin
      st_next.mask = lk.mask_data;  // Only a mask write changes it
    end
  end

  // State register, mask at all ones from power-on
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_reg.mask <= tce_pkg::MASK_RST;
      st_reg.cond_prev <= 16'h0000;
      st_reg.event_bits <= 16'h0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lk.mask = st_reg.mask;
  assign lk.event_bits = st_reg.event_bits;

  a_rise_sets_event: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (rise != 16'h0000) |=> (st_reg.event_bits & $past(rise)) == $past(rise)
  ) else $error("masked rising change did not set its event bit");

  a_mask_held: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    !lk.mask_wr |=> st_reg.mask == $past(st_reg.mask)
  ) else $error("filter mask changed without a mask write");

endmodule

//--- design/tce_link_if.sv
// Carrier between the command logic, the error queue and the filter
`timescale 1ns/1ns
interface tce_link_if;
  // Error queue side
  logic push;
  logic [15:0] push_num;
  logic [7:0] push_msg;
  logic pop;
  logic clear;
  logic [15:0] head_num;
  logic [7:0] head_msg;
  logic empty;
  // Rising filter side
  logic mask_wr;
  logic [15:0] mask_data;
  logic ev_rd;
  logic [15:0] cond;
  logic [15:0] mask;
  logic [15:0] event_bits;

  modport ctl (
    output push, push_num, push_msg, pop, clear,
    output mask_wr, mask_data, ev_rd, cond,
    input head_num, head_msg, empty, mask, event_bits
  );
  modport queue (
    input push, push_num, push_msg, pop, clear,
    output head_num, head_msg, empty
  );
  modport filt (
    input mask_wr, mask_data, ev_rd, cond,
    output mask, event_bits
  );
endinterface

//--- design/tce_pkg.sv
// Shared constants and types of the trigger count and error queue block
package tce_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int CNT_W = 16;
  localparam int PLUG_W = 8;
  localparam int REMOTE_W = 4;
  localparam int N_CH = 64;
  localparam int ERRQ_DEPTH = 8;
  localparam int ERRQ_AW = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] COUNT_RST = 16'h0000;  // Zero means unlimited
  localparam logic [15:0] COUNT_UNLIMITED = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'hFFFF;   // Power-on: all ones

  // ****************************************************************
  // Channel addressing
  // ****************************************************************
  localparam logic [15:0] CH_FIRST = 16'h0064;     // 100
  localparam logic [15:0] CH_LAST = 16'h00A3;      // 163
  localparam logic [15:0] CH_LONG_MIN = 16'h2710;  // 10000, 5-digit form
  localparam logic [15:0] CH_REMOTE_MAX = 16'h3D73; // 15731
  localparam logic [15:0] CH_DIV = 16'h0064;       // Strips sub-channel

  // ****************************************************************
  // Answer numbers and text codes
  // ****************************************************************
  localparam logic [31:0] VERSION_NUM = 32'h000007C6;  // 1990
  localparam logic [31:0] ERR_ILLEGAL_PARAM = 32'hFFFFFF20;  // -224
  localparam logic [31:0] ERR_UNDEFINED = 32'hFFFFFF8F;      // -113
  localparam logic [15:0] ERR_QUEUE_OVERFLOW = 16'hFEA2;     // -350
  localparam logic [7:0] TXT_NONE = 8'h00;
  localparam logic [7:0] TXT_NO_ERROR = 8'h01;
  localparam logic [7:0] TXT_VERSION = 8'h02;
  localparam logic [7:0] TXT_NO_PLUG_ON = 8'h03;
  localparam logic [7:0] TXT_NO_DEVICE = 8'h04;
  localparam logic [7:0] TXT_ILLEGAL_PARAM = 8'h05;
  localparam logic [7:0] TXT_QUEUE_OVERFLOW = 8'h06;
  localparam logic [7:0] TXT_UNDEFINED = 8'h07;

  // ****************************************************************
  // Host command set
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_SET_COUNT, OP_SET_UNLIMITED, OP_QUERY_COUNT, OP_ERROR_READ,
    OP_VERSION, OP_PLUG_TYPE, OP_REMOTE_TYPE, OP_MASK_WRITE,
    OP_MASK_QUERY, OP_EVENT_READ, OP_ARM, OP_ABORT, OP_FULL_RESET
  } tce_op_t;

endpackage

//--- design/tce_top.sv
// Trigger count sequencing and system query logic
//
// What this block does
// - Holds a count 0..65535; after arming accepts that many triggers.
// - Count zero means unlimited: return to waiting after every trigger.
// - Abort or full reset returns to idle; abort keeps configuration.
// - After reset the trigger count is zero, unlimited.
// - A count query returns the stored count; zero means unlimited.
// - At most one algorithm pass per accepted trigger; extras ignored.
// - No passes once triggers stop or the count runs out.
// - Each error read returns one signed entry and removes it.
// - Empty queue answers zero with a no-error message.
// - A full reset command empties the error queue.
// - Version query answers the fixed 1990 language version.
// - Mask query returns the 16-bit rising filter mask; a full reset command keeps it.
// - Plug-on query takes one channel 100..163; empty slot says none.
// - Remote query takes channel up to 15731, short or long form.
// - A set filter bit lets a rising condition set its event bit.
`timescale 1ns/1ns
module tce_top (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // Host command
  input wire logic CMD_VALID_I,
  input wire tce_pkg::tce_op_t CMD_OP_I,
  input wire logic [15:0] CMD_ARG_I,
  // Trigger and algorithm handshake
  input wire logic TRIG_I,
  input wire logic ALG_DONE_I,
  // Error sources and status conditions
  input wire logic ERR_PUSH_I,
  input wire logic [15:0] ERR_NUM_I,
  input wire logic [7:0] ERR_MSG_I,
  input wire logic [15:0] COND_I,
  // Attached unit types per channel slot, zero means absent
  input wire logic [63:0][7:0] PLUG_TYPE_I,
  input wire logic [63:0][3:0] REMOTE_TYPE_I,
  // Answer to host
  output logic RESP_VALID_O,
  output logic [31:0] RESP_NUM_O,
  output logic [7:0] RESP_TEXT_O,
  // Trigger system state
  output logic ALG_START_O,
  output logic TRIG_IDLE_O,
  output logic WAIT_TRIG_O
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} tce_trig_t;

  typedef struct packed {
    tce_trig_t state;
    logic unlimited;
    logic [15:0] remaining;
    logic [15:0] count;
    logic alg_start;
    logic idle;
    logic waiting;
    logic resp_valid;
    logic [31:0] resp_num;
    logic [7:0] resp_txt;
  } tce_top_st_t;

  tce_top_st_t st_reg;
  tce_top_st_t st_next;
  logic [6:0] slot;
  logic [7:0] plug_type;
  logic [3:0] remote_type;

  tce_link_if lk ();

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  tce_errq u_errq (
    .CLK_SYS_I(CLK_SYS_I),
    .ARST_N_I(ARST_N_I),
    .lk(lk.queue)
  );

  tce_filt u_filt (
    .CLK_SYS_I(CLK_SYS_I),
    .ARST_N_I(ARST_N_I),
    .lk(lk.filt)
  );

  // ****************************************************************
  // Channel decode
  // ****************************************************************
  // Returns {valid, slot}; long form drops the two sub-channel digits
  function automatic logic [6:0] chan_slot(input logic [15:0] ch,
                                           input logic long_ok);
    logic [15:0] base;
    base = ch;
    if (long_ok && ch >= tce_pkg::CH_LONG_MIN &&
        ch <= tce_pkg::CH_REMOTE_MAX) begin
      base = ch / tce_pkg::CH_DIV;
    end
    if (base >= tce_pkg::CH_FIRST && base <= tce_pkg::CH_LAST) begin
      chan_slot = {1'b1, 6'(base - tce_pkg::CH_FIRST)};
    end else begin
      chan_slot = 7'h00;
    end
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Trigger sequencing first, then the host command, which may override
  always_comb begin
    st_next = st_reg;
    st_next.alg_start = 1'b0;
    st_next.resp_valid = 1'b0;
    slot = 7'h00;
    plug_type = 8'h00;
    remote_type = 4'h0;
    lk.push = ERR_PUSH_I;
    lk.push_num = ERR_NUM_I;
    lk.push_msg = ERR_MSG_I;
    lk.pop = 1'b0;
    lk.clear = 1'b0;
    lk.mask_wr = 1'b0;
    lk.mask_data = CMD_ARG_I;
    lk.ev_rd = 1'b0;
    lk.cond = COND_I;

    // Triggers while a pass runs are dropped, never queued
    unique case (st_reg.state)
      ST_IDLE: begin
        st_next.state = ST_IDLE;
      end
      ST_WAIT: begin
        if (TRIG_I) begin
          st_next.alg_start = 1'b1;
          st_next.state = ST_RUN;
          if (!st_reg.unlimited) begin
            st_next.remaining = st_reg.remaining - 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (ALG_DONE_I) begin
          if (!st_reg.unlimited && st_reg.remaining == 16'h0000) begin
            st_next.state = ST_IDLE;
          end else begin
            st_next.state = ST_WAIT;
          end
        end
      end
    endcase

    if (CMD_VALID_I) begin
      st_next.resp_valid = 1'b1;
      st_next.resp_num = 32'h00000000;
      st_next.resp_txt = tce_pkg::TXT_NONE;
      case (CMD_OP_I)
        tce_pkg::OP_SET_COUNT: begin
          st_next.count = CMD_ARG_I;
        end
        tce_pkg::OP_SET_UNLIMITED: begin
          st_next.count = tce_pkg::COUNT_UNLIMITED;
        end
        tce_pkg::OP_QUERY_COUNT: begin
          st_next.resp_num = {16'h0000, st_reg.count};
        end
        tce_pkg::OP_ERROR_READ: begin
          if (lk.empty) begin
            st_next.resp_txt = tce_pkg::TXT_NO_ERROR;
          end else begin
            st_next.resp_num = {{16{lk.head_num[15]}}, lk.head_num};
            st_next.resp_txt = lk.head_msg;
            lk.pop = 1'b1;
          end
        end
        tce_pkg::OP_VERSION: begin
          st_next.resp_num = tce_pkg::VERSION_NUM;
          st_next.resp_txt = tce_pkg::TXT_VERSION;
        end
        tce_pkg::OP_PLUG_TYPE: begin
          slot = chan_slot(CMD_ARG_I, 1'b0);
          plug_type = PLUG_TYPE_I[slot[5:0]];
          if (!slot[6]) begin
            st_next.resp_num = tce_pkg::ERR_ILLEGAL_PARAM;
            st_next.resp_txt = tce_pkg::TXT_ILLEGAL_PARAM;
          end else if (plug_type == 8'h00) begin
            st_next.resp_txt = tce_pkg::TXT_NO_PLUG_ON;
          end else begin
            st_next.resp_num = {24'h000000, plug_type};
          end
        end
        tce_pkg::OP_REMOTE_TYPE: begin
          slot = chan_slot(CMD_ARG_I, 1'b1);
          remote_type = REMOTE_TYPE_I[slot[5:0]];
          if (!slot[6]) begin
            st_next.resp_num = tce_pkg::ERR_ILLEGAL_PARAM;
            st_next.resp_txt = tce_pkg::TXT_ILLEGAL_PARAM;
          end else if (remote_type == 4'h0) begin
            st_next.resp_txt = tce_pkg::TXT_NO_DEVICE;
          end else begin
            st_next.resp_num = {28'h0000000, remote_type};
          end
        end
        tce_pkg::OP_MASK_WRITE: begin
          lk.mask_wr = 1'b1;
        end
        tce_pkg::OP_MASK_QUERY: begin
          st_next.resp_num = {16'h0000, lk.mask};
        end
        tce_pkg::OP_EVENT_READ: begin
          st_next.resp_num = {16'h0000, lk.event_bits};
          lk.ev_rd = 1'b1;
        end
        tce_pkg::OP_ARM: begin
          // Arming an armed system is ignored, the run goes on
          if (st_reg.state == ST_IDLE) begin
            st_next.state = ST_WAIT;
            st_next.remaining = st_reg.count;
            st_next.unlimited = (st_reg.count == tce_pkg::COUNT_UNLIMITED);
          end
        end
        tce_pkg::OP_ABORT: begin
          st_next.state = ST_IDLE;
          st_next.alg_start = 1'b0;
        end
        tce_pkg::OP_FULL_RESET: begin
          st_next.state = ST_IDLE;
          st_next.alg_start = 1'b0;
          st_next.count = tce_pkg::COUNT_RST;
          lk.clear = 1'b1;
        end
        default: begin
          st_next.resp_num = tce_pkg::ERR_UNDEFINED;
          st_next.resp_txt = tce_pkg::TXT_UNDEFINED;
        end
      endcase
    end

    // Decoded state kept in flops so the outputs are registered
    st_next.idle = (st_next.state == ST_IDLE);
    st_next.waiting = (st_next.state == ST_WAIT);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.count <= tce_pkg::COUNT_RST;
      st_reg.idle <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign RESP_VALID_O = st_reg.resp_valid;
  assign RESP_NUM_O = st_reg.resp_num;
  assign RESP_TEXT_O = st_reg.resp_txt;
  assign ALG_START_O = st_reg.alg_start;
  assign TRIG_IDLE_O = st_reg.idle;
  assign WAIT_TRIG_O = st_reg.waiting;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_abort_to_idle: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (CMD_VALID_I && (CMD_OP_I == tce_pkg::OP_ABORT ||
                     CMD_OP_I == tce_pkg::OP_FULL_RESET))
      |=> TRIG_IDLE_O && !ALG_START_O
  ) else $error("abort or reset left the trigger system armed");

  a_reset_count_zero: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (CMD_VALID_I && CMD_OP_I == tce_pkg::OP_FULL_RESET)
      |=> st_reg.count == 16'h0000
  ) else $error("reset did not load a zero trigger count");

  a_count_answer: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (CMD_VALID_I && CMD_OP_I == tce_pkg::OP_QUERY_COUNT)
      |=> RESP_VALID_O && RESP_NUM_O == {16'h0000, $past(st_reg.count)}
  ) else $error("count query answer differs from stored count");

  a_count_exhausted: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (st_reg.state == ST_RUN && ALG_DONE_I && !st_reg.unlimited &&
     st_reg.remaining == 16'h0000 && !CMD_VALID_I)
      |=> TRIG_IDLE_O ##1 !ALG_START_O
  ) else $error("trigger system stayed armed after its last trigger");

  a_unlimited_rewait: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (st_reg.state == ST_RUN && ALG_DONE_I && st_reg.unlimited &&
     !CMD_VALID_I) |=> WAIT_TRIG_O
  ) else $error("unlimited count did not return to waiting");

  a_one_pass: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (ALG_START_O && !ALG_DONE_I) |=> !ALG_START_O && !WAIT_TRIG_O
  ) else $error("second pass started without a new accepted trigger");

  a_idle_no_pass: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    TRIG_IDLE_O |=> !ALG_START_O
  ) else $error("pass started while the trigger system was idle");

  a_version_answer: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (CMD_VALID_I && CMD_OP_I == tce_pkg::OP_VERSION)
      |=> RESP_NUM_O == tce_pkg::VERSION_NUM &&
          RESP_TEXT_O == tce_pkg::TXT_VERSION
  ) else $error("version query gave the wrong answer");

  a_empty_no_error: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (CMD_VALID_I && CMD_OP_I == tce_pkg::OP_ERROR_READ && lk.empty)
      |=> RESP_NUM_O == 32'h00000000 &&
          RESP_TEXT_O == tce_pkg::TXT_NO_ERROR
  ) else $error("empty queue read did not answer no error");

endmodule

//--- tb/tce_alg_model.sv
// Algorithm engine model answering each start with a done pulse
`timescale 1ns/1ns
module tce_alg_model (
  // Clock
  input wire logic CLK_SYS_I,
  // Handshake with the block
  input wire logic start_i,
  input wire logic [31:0] lat_i,
  output logic done_o
);
  // ****************************************************************
  // Pass engine
  // ****************************************************************
  initial done_o = 1'b0;
  // One pass per start; latency set by the bench, fast or slow
  always @(posedge CLK_SYS_I) begin
    if (start_i === 1'b1) begin
      repeat (lat_i) @(negedge CLK_SYS_I);
      done_o = 1'b1;
      @(negedge CLK_SYS_I);
      done_o = 1'b0;
    end
  end
endmodule

//--- tb/tce_top_bench.sv
// Self-checking bench of the trigger count and error queue block
`timescale 1ns/1ns
module tce_top_bench;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_v = 1'b0;
  tce_pkg::tce_op_t op = tce_pkg::OP_QUERY_COUNT;
  logic [15:0] arg = 16'h0000;
  logic trig = 1'b0;
  logic alg_done;
  logic e_push = 1'b0;
  logic [15:0] e_num = 16'h0000;
  logic [7:0] e_msg = 8'h00;
  logic [15:0] cond = 16'h0000;
  logic [63:0][7:0] plug = '0;
  logic [63:0][3:0] remote = '0;
  logic r_v, a_start, t_idle, w_trig;
  logic [31:0] r_num;
  logic [7:0] r_txt;
  int lat = 1;
  int starts = 0;
  int err_total = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  tce_top dut (
    .CLK_SYS_I(clk), .ARST_N_I(arst_n), .CMD_VALID_I(cmd_v),
    .CMD_OP_I(op), .CMD_ARG_I(arg), .TRIG_I(trig),
    .ALG_DONE_I(alg_done), .ERR_PUSH_I(e_push), .ERR_NUM_I(e_num),
    .ERR_MSG_I(e_msg), .COND_I(cond), .PLUG_TYPE_I(plug),
    .REMOTE_TYPE_I(remote), .RESP_VALID_O(r_v), .RESP_NUM_O(r_num),
    .RESP_TEXT_O(r_txt), .ALG_START_O(a_start), .TRIG_IDLE_O(t_idle),
    .WAIT_TRIG_O(w_trig)
  );

  tce_alg_model alg (
    .CLK_SYS_I(clk), .start_i(a_start), .lat_i(lat), .done_o(alg_done)
  );

  // Pass counter; every start pulse is one pass
  always @(posedge clk) if (a_start === 1'b1) starts++;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e, got);
    samples_checked++;
    if (got !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, got);
    end
  endtask

  // One command; answer looked at in its single valid cycle
  task automatic cmd(input tce_pkg::tce_op_t o, input logic [15:0] a,
                     input logic [31:0] en, input logic [7:0] et,
                     input bit ct);
    @(negedge clk);
    op = o;
    arg = a;
    cmd_v = 1'b1;
    @(negedge clk);
    cmd_v = 1'b0;
    chk("resp_valid", 32'h1, {31'h0, r_v});
    chk("resp_num", en, r_num);
    if (ct) chk("resp_text", {24'h0, et}, {24'h0, r_txt});
  endtask

  // Bounded wait for idle (1) or waiting-for-trigger (0)
  task automatic wait_lvl(input bit idle);
    for (int i = 0; i < 40; i++) begin
      if ((idle ? t_idle : w_trig) === 1'b1) return;
      @(negedge clk);
    end
    err_total++;
    $display("unexpected wait_level expected 1 seen 0");
    close_out();
  endtask

  task automatic pulse_trig();
    @(negedge clk);
    trig = 1'b1;
    @(negedge clk);
    trig = 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    cmd(tce_pkg::OP_QUERY_COUNT, 16'h0, 32'h0, 8'h0, 0);
    cmd(tce_pkg::OP_MASK_QUERY, 16'h0, 32'hFFFF, 8'h0, 0);
    cmd(tce_pkg::OP_ERROR_READ, 16'h0, 32'h0,
        tce_pkg::TXT_NO_ERROR, 1);
    cmd(tce_pkg::OP_VERSION, 16'h0, 32'h7C6, tce_pkg::TXT_VERSION, 1);
  endtask

  // Count two: two passes, surplus triggers in run and idle dropped
  task automatic t_limited();
    lat = 4;
    starts = 0;
    cmd(tce_pkg::OP_SET_COUNT, 16'h0002, 32'h0, tce_pkg::TXT_NONE, 1);
    cmd(tce_pkg::OP_ARM, 16'h0, 32'h0, tce_pkg::TXT_NONE, 1);
    wait_lvl(0);
    pulse_trig();
    chk("alg_start", 32'h1, {31'h0, a_start});
    pulse_trig();
    wait_lvl(0);
    pulse_trig();
    wait_lvl(1);
    pulse_trig();
    repeat (6) @(negedge clk);
    chk("passes", 32'd2, starts);
    cmd(tce_pkg::OP_QUERY_COUNT, 16'h0, 32'h2, 8'h0, 0);
  endtask

  // Unlimited count keeps waiting; abort returns to idle, keeps config
  task automatic t_unlimited();
    lat = 1;
    starts = 0;
    cmd(tce_pkg::OP_MASK_WRITE, 16'h0004, 32'h0, 8'h0, 0);
    cmd(tce_pkg::OP_SET_UNLIMITED, 16'h0, 32'h0, 8'h0, 0);
    cmd(tce_pkg::OP_ARM, 16'h0, 32'h0, 8'h0, 0);
    for (int i = 0; i < 3; i++) begin
      wait_lvl(0);
      pulse_trig();
    end
    wait_lvl(0);
    chk("passes", 32'd3, starts);
    cmd(tce_pkg::OP_ABORT, 16'h0, 32'h0, 8'h0, 0);
    chk("trig_idle", 32'h1, {31'h0, t_idle});
    cmd(tce_pkg::OP_MASK_QUERY, 16'h0, 32'h4, 8'h0, 0);
  endtask

  // Pop one entry, then empty; full reset empties, mask kept
  task automatic t_errq();
    @(negedge clk);
    e_num = 16'hFF9C;
    e_msg = 8'h11;
    e_push = 1'b1;
    @(negedge clk);
    e_push = 1'b0;
    cmd(tce_pkg::OP_ERROR_READ, 16'h0, 32'hFFFFFF9C, 8'h11, 1);
    cmd(tce_pkg::OP_ERROR_READ, 16'h0, 32'h0,
        tce_pkg::TXT_NO_ERROR, 1);
    e_push = 1'b1;
    @(negedge clk);
    e_push = 1'b0;
    cmd(tce_pkg::OP_FULL_RESET, 16'h0, 32'h0, 8'h0, 0);
    cmd(tce_pkg::OP_ERROR_READ, 16'h0, 32'h0,
        tce_pkg::TXT_NO_ERROR, 1);
    cmd(tce_pkg::OP_MASK_QUERY, 16'h0, 32'h4, 8'h0, 0);
  endtask

  // Only the masked bit of two rising conditions is latched
  task automatic t_filter();
    @(negedge clk);
    cond = 16'h000C;
    repeat (2) @(negedge clk);
    cmd(tce_pkg::OP_EVENT_READ, 16'h0, 32'h4, 8'h0, 0);
    cmd(tce_pkg::OP_EVENT_READ, 16'h0, 32'h0, 8'h0, 0);
  endtask

  // Channel slots: present, empty, out of range, long form
  task automatic t_slots();
    cmd(tce_pkg::OP_PLUG_TYPE, 16'd105, 32'h3C, 8'h0, 0);
    cmd(tce_pkg::OP_PLUG_TYPE, 16'd106, 32'h0,
        tce_pkg::TXT_NO_PLUG_ON, 1);
    cmd(tce_pkg::OP_PLUG_TYPE, 16'd164, 32'hFFFFFF20,
        tce_pkg::TXT_ILLEGAL_PARAM, 1);
    cmd(tce_pkg::OP_REMOTE_TYPE, 16'd10700, 32'h9, 8'h0, 0);
    cmd(tce_pkg::OP_REMOTE_TYPE, 16'd108, 32'h0,
        tce_pkg::TXT_NO_DEVICE, 1);
    cmd(tce_pkg::OP_REMOTE_TYPE, 16'd15800, 32'hFFFFFF20,
        tce_pkg::TXT_ILLEGAL_PARAM, 1);
  endtask

  // ****************************************************************
  // Verdict and main sequence
  // ****************************************************************
  task automatic close_out();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    plug[5] = 8'h3C;
    remote[7] = 4'h9;
    repeat (4) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_limited();
    t_unlimited();
    t_errq();
    t_filter();
    t_slots();
    close_out();
  end
endmodule
